// ==== rtl/crmq_pkg.sv ====
// Summary of operation
// - On publishing a receive list the record count is set to the frames placed and held until the gateway and application receive counters match again.
// - The gateway receive counter advances only when new frames are pending and it equals the application receive counter.
// - The 16-bit gateway transmit counter advances once the master's transmit records have been copied into the local send queue.
// - The record count gives the records following in the image when the receive counter advanced, from one up to the slot count.
// - Sub-index four reports the transaction number of the most recently sent transmit message.
// - A standard record is ten octets: length in bits 0-3, remote flag in bit 4, 11-bit identifier in bits 5-15, data in bits 16-79.
// - An extended record is fourteen octets: length in bits 0-3, identifier in bits 16-44, remote flag in bit 46, data in bits 48-111.
// - In extended records bit 47 is zero for an 11-bit identifier and one for a 29-bit identifier.
// - Frames with 29-bit identifiers go through the extended queue, not the standard one.
// - The standard queue exposes read-only the 8-bit sub-entry count, the four 16-bit entries, then the records.
package crmq_pkg;

    localparam int          SLOTS        = 8;
    localparam int          SLOT_W       = 3;
    localparam int          SCNT_W       = 4;
    localparam int          STD_REC_W    = 80;
    localparam int          EXT_REC_W    = 112;
    localparam int          FRAME_W      = 99;

    // Sub-index map of each queue object
    localparam logic [7:0]  SUB_NUM      = 8'h00;
    localparam logic [7:0]  SUB_TX_CNT   = 8'h01;
    localparam logic [7:0]  SUB_RX_CNT   = 8'h02;
    localparam logic [7:0]  SUB_REC_CNT  = 8'h03;
    localparam logic [7:0]  SUB_TRANS    = 8'h04;
    localparam logic [7:0]  SUB_REC0     = 8'h05;
    localparam logic [7:0]  SUB_COUNT    = 8'h0c;

    // Record field positions
    localparam int          DLC_LSB      = 0;
    localparam int          STD_RTR_BIT  = 4;
    localparam int          STD_ID_LSB   = 5;
    localparam int          DATA_LSB     = 16;
    localparam int          EXT_ID_LSB   = 16;
    localparam int          EXT_RTR_BIT  = 46;
    localparam int          EXT_TYPE_BIT = 47;
    localparam int          EXT_DATA_LSB = 48;
    localparam logic [3:0]  DLC_MAX      = 4'h8;

    // Frame word layout inside the buffer
    localparam int          FR_DATA_LSB  = 0;
    localparam int          FR_DLC_LSB   = 64;
    localparam int          FR_RTR_BIT   = 68;
    localparam int          FR_ID_LSB    = 69;
    localparam int          FR_EXT_BIT   = 98;

    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] CNT_ONE      = 16'h0001;

endpackage

// ==== rtl/crmq_buf.sv ====
`timescale 1ns/1ns
module crmq_buf
    import crmq_pkg::*;
#(
    parameter int DW = FRAME_W
)(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [DW-1:0] in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic      [DW-1:0] out_data
);

    typedef struct packed {
        logic [1:0][DW-1:0] mem;
        logic               wp;
        logic               rp;
        logic [1:0]         cnt;
        logic               rdy;
    } crmq_buf_s;

    crmq_buf_s s_q;
    crmq_buf_s s_d;
    logic      push;
    logic      pop;

    assign out_valid = (s_q.cnt != 2'h0);
    assign out_data  = s_q.mem[s_q.rp];
    assign in_ready  = s_q.rdy;

    always_comb
    begin
        s_d  = s_q;
        push = in_valid && s_q.rdy;
        pop  = out_valid && out_ready;
        if (push)
        begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = ~s_q.wp;
        end
        if (pop)
        begin
            s_d.rp = ~s_q.rp;
        end
        s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
        // Ready is registered so the source sees a clean flop
        s_d.rdy = (s_d.cnt != 2'h2);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q     <= '0;
            s_q.rdy <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule // crmq_buf

// ==== rtl/crmq_top.sv ====
`timescale 1ns/1ns
module crmq_top
    import crmq_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         frame_valid,
    output logic              frame_ready,
    input  wire logic         frame_ext,
    input  wire logic [28:0]  frame_id,
    input  wire logic         frame_rtr,
    input  wire logic [3:0]   frame_dlc,
    input  wire logic [63:0]  frame_data,
    input  wire logic [15:0]  app_rx_std,
    input  wire logic [15:0]  app_rx_ext,
    input  wire logic         tx_copied_std,
    input  wire logic         tx_copied_ext,
    input  wire logic         tx_sent_valid,
    input  wire logic         tx_sent_ext,
    input  wire logic [15:0]  tx_sent_trans,
    input  wire logic         img_rd_en,
    input  wire logic         img_rd_ext,
    input  wire logic [7:0]   img_sub_index,
    output logic      [111:0] img_rd_data,
    output logic              img_rd_valid
);

    typedef struct packed {
        logic [SLOTS-1:0][STD_REC_W-1:0] std_stage;
        logic [SLOTS-1:0][STD_REC_W-1:0] std_pub;
        logic [SLOTS-1:0][EXT_REC_W-1:0] ext_stage;
        logic [SLOTS-1:0][EXT_REC_W-1:0] ext_pub;
        logic [SCNT_W-1:0]               std_scnt;
        logic [SCNT_W-1:0]               ext_scnt;
        logic [15:0]                     std_gw_tx;
        logic [15:0]                     std_gw_rx;
        logic [15:0]                     std_rec;
        logic [15:0]                     std_trans;
        logic [15:0]                     ext_gw_tx;
        logic [15:0]                     ext_gw_rx;
        logic [15:0]                     ext_rec;
        logic [15:0]                     ext_trans;
        logic [111:0]                    rd_data;
        logic                            rd_valid;
    } crmq_top_s;

    crmq_top_s          s_q;
    crmq_top_s          s_d;
    logic [FRAME_W-1:0] fr_in;
    logic [FRAME_W-1:0] fr;
    logic               fr_valid;
    logic               fr_ready;
    logic               fr_is_ext;
    logic               pub_std;
    logic               pub_ext;
    logic [7:0]         rec_sub;

    // Length codes above eight still mean eight data bytes
    function automatic logic [3:0] clamp_dlc(input logic [3:0] dlc);
        clamp_dlc = (dlc > DLC_MAX) ? DLC_MAX : dlc;
    endfunction

    function automatic logic [STD_REC_W-1:0] std_record(input logic [FRAME_W-1:0] f);
        std_record                              = '0;
        std_record[DLC_LSB +: 4]                = clamp_dlc(f[FR_DLC_LSB +: 4]);
        std_record[STD_RTR_BIT]                 = f[FR_RTR_BIT];
        std_record[STD_ID_LSB +: 11]            = f[FR_ID_LSB +: 11];
        std_record[DATA_LSB +: 64]              = f[FR_DATA_LSB +: 64];
    endfunction

    function automatic logic [EXT_REC_W-1:0] ext_record(input logic [FRAME_W-1:0] f);
        ext_record                              = '0;
        ext_record[DLC_LSB +: 4]                = clamp_dlc(f[FR_DLC_LSB +: 4]);
        ext_record[EXT_ID_LSB +: 29]            = f[FR_ID_LSB +: 29];
        ext_record[EXT_RTR_BIT]                 = f[FR_RTR_BIT];
        ext_record[EXT_TYPE_BIT]                = f[FR_EXT_BIT];
        ext_record[EXT_DATA_LSB +: 64]          = f[FR_DATA_LSB +: 64];
    endfunction

    // Header entries shared by both queue objects
    function automatic logic [15:0] hdr_entry(input logic [7:0]  sub,
                                              input logic [15:0] tx,
                                              input logic [15:0] rx,
                                              input logic [15:0] rec,
                                              input logic [15:0] trans);
        unique case (sub)
            SUB_NUM:     hdr_entry = {8'h00, SUB_COUNT};
            SUB_TX_CNT:  hdr_entry = tx;
            SUB_RX_CNT:  hdr_entry = rx;
            SUB_REC_CNT: hdr_entry = rec;
            SUB_TRANS:   hdr_entry = trans;
            default:     hdr_entry = 16'h0000;
        endcase
    endfunction

    assign fr_in = {frame_ext, frame_id, frame_rtr, frame_dlc, frame_data};

    crmq_buf #(
        .DW        (FRAME_W)
    ) u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (frame_valid),
        .in_ready  (frame_ready),
        .in_data   (fr_in),
        .out_valid (fr_valid),
        .out_ready (fr_ready),
        .out_data  (fr)
    );

    assign fr_is_ext = fr[FR_EXT_BIT];

    // Publish only while the master has acknowledged the previous list
    assign pub_std = (s_q.std_scnt != '0) && (s_q.std_gw_rx == app_rx_std);
    assign pub_ext = (s_q.ext_scnt != '0) && (s_q.ext_gw_rx == app_rx_ext);

    // A full staging area stalls the buffer, which then stalls the source
    assign fr_ready = fr_is_ext ? ((s_q.ext_scnt < SCNT_W'(SLOTS)) && !pub_ext)
                                : ((s_q.std_scnt < SCNT_W'(SLOTS)) && !pub_std);

    assign rec_sub = 8'(img_sub_index - SUB_REC0);

    always_comb
    begin
        s_d = s_q;

        if (fr_valid && fr_ready)
        begin
            if (fr_is_ext)
            begin
                s_d.ext_stage[s_q.ext_scnt[SLOT_W-1:0]] = ext_record(fr);
                s_d.ext_scnt = SCNT_W'(s_q.ext_scnt + 1'b1);
            end
            else
            begin
                s_d.std_stage[s_q.std_scnt[SLOT_W-1:0]] = std_record(fr);
                s_d.std_scnt = SCNT_W'(s_q.std_scnt + 1'b1);
            end
        end

        // Staging is cleared on publish, so unused slots stay zero
        if (pub_std)
        begin
            s_d.std_pub   = s_q.std_stage;
            s_d.std_stage = '0;
            s_d.std_scnt  = '0;
            s_d.std_rec   = 16'(s_q.std_scnt);
            s_d.std_gw_rx = 16'(s_q.std_gw_rx + CNT_ONE);
        end
        if (pub_ext)
        begin
            s_d.ext_pub   = s_q.ext_stage;
            s_d.ext_stage = '0;
            s_d.ext_scnt  = '0;
            s_d.ext_rec   = 16'(s_q.ext_scnt);
            s_d.ext_gw_rx = 16'(s_q.ext_gw_rx + CNT_ONE);
        end

        if (tx_copied_std)
        begin
            s_d.std_gw_tx = 16'(s_q.std_gw_tx + CNT_ONE);
        end
        if (tx_copied_ext)
        begin
            s_d.ext_gw_tx = 16'(s_q.ext_gw_tx + CNT_ONE);
        end

        if (tx_sent_valid)
        begin
            if (tx_sent_ext)
            begin
                s_d.ext_trans = tx_sent_trans;
            end
            else
            begin
                s_d.std_trans = tx_sent_trans;
            end
        end

        // Image read: the whole image is read-only, unmapped entries read zero
        s_d.rd_valid = img_rd_en;
        if (img_rd_en)
        begin
            s_d.rd_data = '0;
            if (img_sub_index < SUB_REC0)
            begin
                s_d.rd_data[15:0] = img_rd_ext
                    ? hdr_entry(img_sub_index, s_q.ext_gw_tx, s_q.ext_gw_rx,
                                s_q.ext_rec, s_q.ext_trans)
                    : hdr_entry(img_sub_index, s_q.std_gw_tx, s_q.std_gw_rx,
                                s_q.std_rec, s_q.std_trans);
            end
            else if (rec_sub < 8'(SLOTS))
            begin
                if (img_rd_ext)
                begin
                    s_d.rd_data = s_q.ext_pub[rec_sub[SLOT_W-1:0]];
                end
                else
                begin
                    s_d.rd_data[STD_REC_W-1:0] = s_q.std_pub[rec_sub[SLOT_W-1:0]];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q           <= '0;
            s_q.std_gw_tx <= CNT_RESET;
            s_q.std_gw_rx <= CNT_RESET;
            s_q.ext_gw_tx <= CNT_RESET;
            s_q.ext_gw_rx <= CNT_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign img_rd_data  = s_q.rd_data;
    assign img_rd_valid = s_q.rd_valid;

    AST_REC_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.std_gw_rx != app_rx_std) |=> $stable(s_q.std_rec))
        else $error("Record count changed before counters matched");

    AST_RX_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.ext_gw_rx != $past(s_q.ext_gw_rx))
        |-> ($past(app_rx_ext) == $past(s_q.ext_gw_rx)) && ($past(s_q.ext_scnt) != '0))
        else $error("Receive counter advanced without pending data or match");

    AST_TX_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_copied_std |=> (s_q.std_gw_tx == 16'($past(s_q.std_gw_tx) + CNT_ONE)))
        else $error("Transmit counter did not advance after copy");

    AST_REC_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pub_std |=> (s_q.std_rec >= CNT_ONE) && (s_q.std_rec <= 16'(SLOTS)))
        else $error("Record count out of range");

    AST_TRANS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tx_sent_valid && tx_sent_ext) |=> (s_q.ext_trans == $past(tx_sent_trans)))
        else $error("Transaction number not reported");

    AST_STD_FMT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fr_valid && fr_ready && !fr_is_ext && (s_q.std_scnt == '0) && !pub_std)
        |=> (s_q.std_stage[0][STD_ID_LSB +: 11] == $past(fr[FR_ID_LSB +: 11]))
            && (s_q.std_stage[0][DLC_LSB +: 4] <= DLC_MAX))
        else $error("Standard record layout wrong");

    AST_EXT_FMT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.ext_pub[0][15:4] == 12'h000) && (s_q.ext_pub[0][45] == 1'b0))
        else $error("Extended record reserved bits not zero");

    AST_ID_TYPE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.ext_rec != CNT_RESET) |-> s_q.ext_pub[0][EXT_TYPE_BIT])
        else $error("Extended record type bit not set");

    AST_ROUTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fr_valid && fr_ready && fr_is_ext)
        |=> (s_q.ext_scnt == SCNT_W'($past(s_q.ext_scnt) + 1'b1)) && $stable(s_q.std_pub))
        else $error("Extended frame not routed to extended queue");

    AST_SUBCNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (img_rd_en && (img_sub_index == SUB_NUM))
        |=> img_rd_valid && (img_rd_data[7:0] == SUB_COUNT))
        else $error("Sub-entry count read wrong");

    AST_UNUSED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.std_rec < 16'(SLOTS)) |-> (s_q.std_pub[SLOTS-1] == '0))
        else $error("Unused slot not zero");

    AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pub_std && (s_q.std_gw_rx == 16'hffff)) |=> (s_q.std_gw_rx == CNT_RESET))
        else $error("Receive counter did not wrap");

    AST_EXT_REC_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.ext_gw_rx != app_rx_ext) |=> $stable(s_q.ext_rec))
        else $error("Extended record count changed before counters matched");

    AST_STD_RX_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.std_gw_rx != $past(s_q.std_gw_rx))
        |-> ($past(app_rx_std) == $past(s_q.std_gw_rx)) && ($past(s_q.std_scnt) != '0))
        else $error("Standard receive counter advanced without pending data or match");

    AST_EXT_TX_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_copied_ext |=> (s_q.ext_gw_tx == 16'($past(s_q.ext_gw_tx) + CNT_ONE)))
        else $error("Extended transmit counter did not advance after copy");

    AST_EXT_REC_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pub_ext |=> (s_q.ext_rec >= CNT_ONE) && (s_q.ext_rec <= 16'(SLOTS)))
        else $error("Extended record count out of range");

    AST_STD_TRANS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tx_sent_valid && !tx_sent_ext) |=> (s_q.std_trans == $past(tx_sent_trans)))
        else $error("Standard transaction number not reported");

    AST_STD_DLC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.std_pub[0][DLC_LSB +: 4] <= DLC_MAX))
        else $error("Standard record length above eight");

    AST_STD_ROUTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fr_valid && fr_ready && !fr_is_ext)
        |=> (s_q.std_scnt == SCNT_W'($past(s_q.std_scnt) + 1'b1)) && $stable(s_q.ext_pub))
        else $error("Standard frame not routed to standard queue");

    AST_RD_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        img_rd_en |=> img_rd_valid)
        else $error("Image read not answered");

    AST_EXT_UNUSED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_q.ext_rec < 16'(SLOTS)) |-> (s_q.ext_pub[SLOTS-1] == '0))
        else $error("Unused extended slot not zero");

    AST_EXT_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pub_ext && (s_q.ext_gw_rx == 16'hffff)) |=> (s_q.ext_gw_rx == CNT_RESET))
        else $error("Extended receive counter did not wrap");

endmodule // crmq_top

// ==== tb/crmq_master_model.sv ====
`timescale 1ns/1ns
module crmq_master_model
    import crmq_pkg::*;
(
    input  wire logic         ref_clk,
    output logic      [15:0]  app_rx_std,
    output logic      [15:0]  app_rx_ext,
    output logic              tx_copied_std,
    output logic              tx_copied_ext,
    output logic              img_rd_en,
    output logic              img_rd_ext,
    output logic      [7:0]   img_sub_index,
    input  wire logic [111:0] img_rd_data,
    input  wire logic         img_rd_valid
);
    initial
    begin
        {app_rx_std, app_rx_ext} = '0;
        {tx_copied_std, tx_copied_ext, img_rd_en} = '0;
        {img_rd_ext, img_sub_index} = '0;
    end

    task automatic read_entry(input logic ext, input logic [7:0] sub,
                              output logic [111:0] d, output logic ok);
        @(posedge ref_clk);
        #1;
        img_rd_en = 1'b1;
        img_rd_ext = ext;
        img_sub_index = sub;
        @(posedge ref_clk);
        #1;
        ok = img_rd_valid;
        d = img_rd_data;
        img_rd_en = 1'b0;
        // Idle select lines must not look like a held request
        img_rd_ext = ~ext;
        img_sub_index = ~sub;
    endtask

    // Only called once the whole list has been read
    task automatic ack(input logic ext);
        @(posedge ref_clk);
        #1;
        if (ext)
            app_rx_ext = app_rx_ext + 16'h0001;
        else
            app_rx_std = app_rx_std + 16'h0001;
    endtask

    // New transmit records written, one copy per cycle held high
    task automatic copy_tx(input logic ext, input int n);
        @(posedge ref_clk);
        #1;
        tx_copied_std = !ext;
        tx_copied_ext = ext;
        repeat (n) @(posedge ref_clk);
        #1;
        {tx_copied_std, tx_copied_ext} = '0;
    endtask
endmodule // crmq_master_model

// ==== tb/test_can_rx_message_queue.sv ====
`timescale 1ns/1ns
module test_can_rx_message_queue
    import crmq_pkg::*;
;
    logic         ref_clk, rst_n, frame_valid, frame_ready, frame_ext, frame_rtr;
    logic [28:0]  frame_id;
    logic [3:0]   frame_dlc;
    logic [63:0]  frame_data;
    logic [15:0]  app_rx_std, app_rx_ext, tx_sent_trans, rnd;
    logic         tx_copied_std, tx_copied_ext, tx_sent_valid, tx_sent_ext;
    logic         img_rd_en, img_rd_ext, img_rd_valid;
    logic [7:0]   img_sub_index;
    logic [111:0] img_rd_data;
    logic [15:0]  m_tx[2], m_rx[2], m_rec[2], m_trans[2];
    logic [111:0] pend[2][$], pub[2][$];
    int           failures, n_tests, cycles;

    crmq_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .frame_ext(frame_ext), .frame_id(frame_id),
        .frame_rtr(frame_rtr), .frame_dlc(frame_dlc), .frame_data(frame_data),
        .app_rx_std(app_rx_std), .app_rx_ext(app_rx_ext), .tx_copied_std(tx_copied_std),
        .tx_copied_ext(tx_copied_ext), .tx_sent_valid(tx_sent_valid),
        .tx_sent_ext(tx_sent_ext), .tx_sent_trans(tx_sent_trans), .img_rd_en(img_rd_en),
        .img_rd_ext(img_rd_ext), .img_sub_index(img_sub_index),
        .img_rd_data(img_rd_data), .img_rd_valid(img_rd_valid));

    crmq_master_model u_master (.ref_clk(ref_clk), .app_rx_std(app_rx_std),
        .app_rx_ext(app_rx_ext), .tx_copied_std(tx_copied_std),
        .tx_copied_ext(tx_copied_ext), .img_rd_en(img_rd_en), .img_rd_ext(img_rd_ext),
        .img_sub_index(img_sub_index), .img_rd_data(img_rd_data),
        .img_rd_valid(img_rd_valid));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic next_rnd();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [111:0] e, input logic [111:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_flag(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic send_frames(input int n, input logic q);
        logic [111:0] r;
        logic [3:0]   dl;
        int           t;
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < n; i++)
        begin
            next_rnd();
            frame_dlc = rnd[3:0];
            frame_rtr = rnd[4];
            frame_id[28:16] = rnd[15:3];
            next_rnd();
            frame_id[15:0] = rnd;
            for (int b = 0; b < 4; b++)
            begin
                next_rnd();
                frame_data[b*16 +: 16] = rnd;
            end
            dl = (frame_dlc > 4'h8) ? 4'h8 : frame_dlc;
            // Bytes past the length are driven to the queue as zero
            for (int b = 0; b < 8; b++)
                if (b >= dl) frame_data[b*8 +: 8] = 8'h00;
            frame_ext = q;
            frame_valid = 1'b1;
            r = '0;
            r[3:0] = dl;
            if (q)
            begin
                {r[111:48], r[47], r[46], r[44:16]} = {frame_data, 1'b1, frame_rtr, frame_id};
            end
            else
                {r[79:16], r[15:5], r[4]} = {frame_data, frame_id[10:0], frame_rtr};
            pend[q].push_back(r);
            t = 0;
            while (frame_ready !== 1'b1 && t < 100)
            begin
                @(posedge ref_clk);
                #1;
                t++;
            end
            if (t == 100) chk_flag("frame_ready wait", 1'b1, frame_ready);
            @(posedge ref_clk);
            #1;
        end
        frame_valid = 1'b0;
        {frame_id, frame_data} = ~{frame_id, frame_data};
    endtask

    task automatic publish(input logic q);
        int n;
        n = (pend[q].size() > 8) ? 8 : pend[q].size();
        if (n > 0)
        begin
            pub[q].delete();
            repeat (n) pub[q].push_back(pend[q].pop_front());
            m_rx[q] = m_rx[q] + 16'h0001;
            m_rec[q] = 16'(n);
        end
    endtask

    task automatic check_image(input logic q);
        logic [111:0] e, d;
        logic         ok;
        for (int s = 0; s < 14; s++)
        begin
            case (s)
                0: e = 112'h0c;
                1: e = 112'(m_tx[q]);
                2: e = 112'(m_rx[q]);
                3: e = 112'(m_rec[q]);
                4: e = 112'(m_trans[q]);
                default: e = (s - 5 < pub[q].size()) ? pub[q][s-5] : '0;
            endcase
            u_master.read_entry(q, 8'(s), d, ok);
            chk_flag($sformatf("q%0d sub%0d valid", q, s), 1'b1, ok);
            chk_word($sformatf("q%0d sub%0d", q, s), e, d);
        end
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    initial
    begin
        {rst_n, frame_valid, frame_ext, frame_rtr, frame_id, frame_dlc, frame_data} = '0;
        {tx_sent_valid, tx_sent_ext, tx_sent_trans} = '0;
        rnd = 16'h2123;
        for (int q = 0; q < 2; q++)
            {m_tx[q], m_rx[q], m_rec[q], m_trans[q]} = '0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        check_image(1'b0);
        check_image(1'b1);
        for (int q = 0; q < 2; q++)
        begin
            send_frames(1, q[0]);
            repeat (10) @(posedge ref_clk);
            publish(q[0]);
            check_image(q[0]);
            send_frames(10, q[0]);
            repeat (10) @(posedge ref_clk);
            #1;
            chk_flag("frame_ready full", 1'b0, frame_ready);
            check_image(q[0]);
            repeat (2)
            begin
                u_master.ack(q[0]);
                repeat (20) @(posedge ref_clk);
                publish(q[0]);
                check_image(q[0]);
            end
            u_master.ack(q[0]);
            repeat (10) @(posedge ref_clk);
            check_image(q[0]);
            next_rnd();
            u_master.copy_tx(q[0], int'(rnd[1:0]) + 1);
            m_tx[q] = m_tx[q] + 16'(rnd[1:0]) + 16'h0001;
            @(posedge ref_clk);
            #1;
            repeat (2)
            begin
                next_rnd();
                tx_sent_valid = 1'b1;
                tx_sent_ext = q[0];
                tx_sent_trans = rnd;
                m_trans[q] = rnd;
                @(posedge ref_clk);
                #1;
            end
            tx_sent_valid = 1'b0;
            tx_sent_trans = ~tx_sent_trans;
            repeat (3) @(posedge ref_clk);
            check_image(q[0]);
            check_image(!q[0]);
        end
        stop_test();
    end
endmodule // test_can_rx_message_queue
